//--- siap_packer.sv
// Function
// [RULE1] Thirteen-byte input assembly; word 0 holds twelve input values, top nibble zero.
// [RULE2] Each input health flag is 0 on fault, 1 when fault-free.
// [RULE3] Word 6 holds twelve test output health flags, upper nibble unused.
// [RULE4] Word 8 holds monitored on/off state of safety outputs 0 to 3.
// [RULE5] Word 10 holds health flags of safety outputs 0 to 3.
// [RULE6] Byte 12 bit 3 is 1 only when every safety input is healthy.
// [RULE7] Byte 12 bit 2 is 1 only when every safety output is healthy.
// [RULE8] Byte 12 bits 4 and 5 carry lamp health of test outputs 3, 7.
// [RULE9] Byte 12 bit 0 is output supply voltage diagnosis, 1 when normal.
// [RULE10] Byte 12 bit 1 is unit supply voltage diagnosis, 1 when normal.
// [RULE11] Byte 12 bit 6 is 0 during output supply overcurrent.
// [RULE12] Byte 12 bit 7 is 0 during unit supply overcurrent.
// [RULE13] Unused inputs report value 0 and health 1.
// [RULE14] One-byte standard output assembly: bits 0 to 3 command safety outputs.
// [RULE15] Four-byte vendor output assembly: safety commands byte 0, test commands word 2.
// [RULE16] Commands for unused terminals and non-standard test outputs are ignored.
// [RULE17] The originator may send an empty configuration block.
// [RULE18] Words travel low byte first at the even offset.
// [RULE19] Every unused input assembly bit is driven zero.
`include "siap_defines.svh"
module siap_packer
  import siap_pkg::*;
(
  input  wire logic        CLK_SYS,
  input  wire logic        RST,
  input  wire siap_in12_t  SAFE_IN_N,
  input  wire siap_in12_t  SAFE_IN_FAULT,
  input  wire siap_in12_t  SAFE_IN_USED,
  input  wire siap_in12_t  TEST_PULSE_OUT,
  input  wire siap_in12_t  TEST_OUT_FAULT,
  input  wire siap_out4_t  SAFE_OUT_MON,
  input  wire siap_out4_t  SAFE_OUT_FAULT,
  input  wire siap_out4_t  SAFE_OUT_USED,
  input  wire siap_power_t POWER_DIAG,
  input  wire logic [23:0] TEST_OUT_FN,
  input  wire logic        TX_START,
  input  wire logic        TX_READY,
  output logic             TX_VALID,
  output logic [7:0]       TX_DATA,
  output logic             TX_LAST,
  input  wire logic        RX_VALID,
  input  wire logic [7:0]  RX_DATA,
  input  wire logic        RX_LAST,
  input  wire siap_asm_t   RX_ASM,
  output siap_out4_t       SAFE_OUT_CMD,
  output siap_in12_t       TEST_OUT_CMD,
  output logic             RX_DONE,
  output logic             RX_ERROR
);
  // Pins from the terminal pass three flops; a change counts on agreement.
  localparam int SW = 12 + 12 + 12 + 12 + 4 + 4 + 6;
  logic [SW-1:0] s1;
  logic [SW-1:0] s2;
  logic [SW-1:0] s3;
  logic [SW-1:0] stable;
  wire  [SW-1:0] raw = {SAFE_IN_N, SAFE_IN_FAULT, TEST_PULSE_OUT,
                        TEST_OUT_FAULT, SAFE_OUT_MON, SAFE_OUT_FAULT,
                        POWER_DIAG};
  wire  [SW-1:0] agree = ~(s2 ^ s3);
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      s1     <= '0;
      s2     <= '0;
      s3     <= '0;
      stable <= '0;
    end else begin
      s1     <= raw;
      s2     <= s1;
      s3     <= s2;
      stable <= (agree & s3) | (~agree & stable);
    end
  end
  wire siap_in12_t  in_val  = stable[SW-1 -: 12];
  wire siap_in12_t  in_flt  = stable[SW-13 -: 12];
  wire siap_in12_t  tp_val  = stable[SW-25 -: 12];
  wire siap_in12_t  tp_flt  = stable[SW-37 -: 12];
  wire siap_out4_t  o_mon   = stable[SW-49 -: 4];
  wire siap_out4_t  o_flt   = stable[SW-53 -: 4];
  wire siap_power_t pw      = stable[5:0];

  // Word fields; unused inputs show value 0 and health 1.
  wire siap_in12_t in_rep  = in_val & SAFE_IN_USED;           // [RULE13]
  wire siap_in12_t in_hlth = ~in_flt | ~SAFE_IN_USED;         // [RULE2] [RULE13]
  wire siap_in12_t tp_hlth = ~tp_flt;                         // [RULE3]
  wire siap_out4_t o_hlth  = ~o_flt | ~SAFE_OUT_USED;         // [RULE5]
  wire all_in_ok  = &in_hlth;                                 // [RULE6]
  wire all_out_ok = &o_hlth;                                  // [RULE7]
  wire [7:0] misc;
  assign misc[`SIAP_MISC_OUT_SUP]  = pw.out_supply_ok;        // [RULE9]
  assign misc[`SIAP_MISC_UNIT_SUP] = pw.unit_supply_ok;       // [RULE10]
  assign misc[`SIAP_MISC_ALL_OUT]  = all_out_ok;              // [RULE7]
  assign misc[`SIAP_MISC_ALL_IN]   = all_in_ok;               // [RULE6]
  // Lamp health is only meaningful on the two lamp-capable test outputs.
  assign misc[`SIAP_MISC_LAMP3] = pw.lamp3_ok & tp_hlth[`SIAP_LAMP_A]; // [RULE8]
  assign misc[`SIAP_MISC_LAMP7] = pw.lamp7_ok & tp_hlth[`SIAP_LAMP_B]; // [RULE8]
  assign misc[`SIAP_MISC_OUT_OC]  = pw.out_oc_ok;             // [RULE11]
  assign misc[`SIAP_MISC_UNIT_OC] = pw.unit_oc_ok;            // [RULE12]

  function automatic logic [7:0] lo12(input siap_in12_t v);
    return v[7:0];
  endfunction
  function automatic logic [7:0] hi12(input siap_in12_t v);
    return {4'h0, v[11:8]};                                   // [RULE19]
  endfunction

  // Byte selection: low byte at the even offset.
  logic [7:0] idx;
  logic [7:0] next_byte;
  always_comb begin
    case (idx)
      8'h00:   next_byte = lo12(in_rep);                      // [RULE1] [RULE18]
      8'h01:   next_byte = hi12(in_rep);                      // [RULE1]
      8'h02:   next_byte = lo12(in_hlth);                     // [RULE2]
      8'h03:   next_byte = hi12(in_hlth);
      8'h04:   next_byte = lo12(tp_val);
      8'h05:   next_byte = hi12(tp_val);
      8'h06:   next_byte = lo12(tp_hlth);                     // [RULE3]
      8'h07:   next_byte = hi12(tp_hlth);                     // [RULE3]
      8'h08:   next_byte = {4'h0, o_mon & SAFE_OUT_USED};     // [RULE4] [RULE19]
      8'h09:   next_byte = 8'h00;                             // [RULE4]
      8'h0A:   next_byte = {4'h0, o_hlth};                    // [RULE5] [RULE19]
      8'h0B:   next_byte = 8'h00;                             // [RULE5]
      8'h0C:   next_byte = misc;
      default: next_byte = 8'h00;                             // [RULE19]
    endcase
  end

  // Bytes are read live; the sender must hold its diagnostics during a frame.
  logic       busy;
  wire        last_idx = (idx == `SIAP_IN_BYTES - 8'h01);
  wire        step     = busy && TX_READY;
  assign TX_VALID = busy;
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      busy    <= 1'b0;
      idx     <= 8'h00;
      TX_DATA <= 8'h00;
      TX_LAST <= 1'b0;
    end else if (!busy && TX_START) begin
      busy    <= 1'b1;
      idx     <= 8'h01;
      TX_DATA <= lo12(in_rep);
      TX_LAST <= 1'b0;
    end else if (step) begin
      busy    <= !TX_LAST;
      idx     <= idx + 8'h01;
      TX_DATA <= next_byte;
      TX_LAST <= last_idx;
    end
  end

  // Output assembly reception.
  logic [7:0] rx_cnt;
  siap_asm_t  rx_kind;
  logic [31:0] rx_word;
  wire  [7:0] rx_len = (RX_ASM == SIAP_ASM_STD) ? `SIAP_STD_OUT_BYTES
               : (RX_ASM == SIAP_ASM_VND) ? `SIAP_VND_OUT_BYTES : 8'h00;
  wire [7:0] exp_len = rx_len;
  wire rx_wr = RX_VALID && (rx_cnt < exp_len);
  wire rx_end = RX_VALID && RX_LAST;
  wire rx_ok  = rx_end && (rx_cnt + 8'h01 == exp_len);
  siap_rx_buf u_buf (
    .clk   (CLK_SYS),
    .rst   (RST),
    .wr    (rx_wr),
    .waddr (rx_cnt[1:0]),
    .wdata (RX_DATA),
    .clr   (1'b0),
    .rdata (rx_word)
  );
  // The buffer's read register lags the last write by one edge, so the
  // commands are applied two edges after the frame is accepted.
  logic apply;
  logic apply_d;
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      rx_cnt   <= 8'h00;
      rx_kind  <= SIAP_ASM_NONE;
      apply    <= 1'b0;
      apply_d  <= 1'b0;
      RX_DONE  <= 1'b0;
      RX_ERROR <= 1'b0;
    end else begin
      rx_cnt   <= rx_end ? 8'h00 : (RX_VALID ? rx_cnt + 8'h01 : rx_cnt);
      apply    <= rx_ok;
      apply_d  <= apply;
      rx_kind  <= rx_ok ? RX_ASM : rx_kind;
      RX_DONE  <= rx_ok;
      RX_ERROR <= rx_end && !rx_ok;
    end
  end
  // Test output command is honoured only for standard-function outputs.
  logic [11:0] test_std;
  always_comb begin
    for (int k = 0; k < 12; k++) begin
      test_std[k] = (TEST_OUT_FN[2*k +: 2] == `SIAP_TEST_FN_STD);
    end
  end
  wire siap_out4_t safe_new = rx_word[3:0] & SAFE_OUT_USED;   // [RULE14] [RULE15] [RULE16]
  wire siap_in12_t test_new = rx_word[16 +: 12];              // [RULE15] [RULE18]
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      SAFE_OUT_CMD <= 4'h0;
      TEST_OUT_CMD <= 12'h000;
    end else if (apply_d) begin
      SAFE_OUT_CMD <= safe_new;
      if (rx_kind == SIAP_ASM_VND) begin
        TEST_OUT_CMD <= (test_new & test_std) |
                        (TEST_OUT_CMD & ~test_std);           // [RULE16]
      end
    end
  end
endmodule

//--- siap_defines.svh
`ifndef SIAP_DEFINES_SVH
`define SIAP_DEFINES_SVH
// Input assembly geometry and byte offsets.
`define SIAP_IN_BYTES      8'h0D
`define SIAP_OFF_INPUTS    8'h00
`define SIAP_OFF_IN_HEALTH 8'h02
`define SIAP_OFF_TEST_VAL  8'h04
`define SIAP_OFF_TEST_HLTH 8'h06
`define SIAP_OFF_OUT_MON   8'h08
`define SIAP_OFF_OUT_HLTH  8'h0A
`define SIAP_OFF_MISC      8'h0C
// Bit positions in the miscellaneous byte.
`define SIAP_MISC_OUT_SUP  0
`define SIAP_MISC_UNIT_SUP 1
`define SIAP_MISC_ALL_OUT  2
`define SIAP_MISC_ALL_IN   3
`define SIAP_MISC_LAMP3    4
`define SIAP_MISC_LAMP7    5
`define SIAP_MISC_OUT_OC   6
`define SIAP_MISC_UNIT_OC  7
// Lamp-capable test outputs.
`define SIAP_LAMP_A        3
`define SIAP_LAMP_B        7
// Output assemblies.
`define SIAP_STD_OUT_BYTES 8'h01
`define SIAP_VND_OUT_BYTES 8'h04
`define SIAP_OFF_SAFE_CMD  8'h00
`define SIAP_OFF_TEST_CMD  8'h02
// Test output function code meaning standard output.
`define SIAP_TEST_FN_STD   2'h0
`endif

//--- siap_pkg.sv
package siap_pkg;
  typedef logic [11:0] siap_in12_t;
  typedef logic [3:0]  siap_out4_t;
  typedef struct packed {
    logic out_supply_ok;
    logic unit_supply_ok;
    logic out_oc_ok;
    logic unit_oc_ok;
    logic lamp3_ok;
    logic lamp7_ok;
  } siap_power_t;
  typedef enum logic [1:0] { SIAP_ASM_NONE, SIAP_ASM_STD, SIAP_ASM_VND }
    siap_asm_t;
endpackage

//--- siap_rx_buf.sv
// Holds the received output assembly; data leave through a register.
module siap_rx_buf
  import siap_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       wr,
  input  wire logic [1:0] waddr,
  input  wire logic [7:0] wdata,
  input  wire logic       clr,
  output logic [31:0]     rdata
);
  logic [7:0] mem [0:3];
  always_ff @(posedge clk) begin
    if (rst || clr) begin
      mem[0] <= 8'h00;
      mem[1] <= 8'h00;
      mem[2] <= 8'h00;
      mem[3] <= 8'h00;
    end else if (wr) begin
      mem[waddr] <= wdata;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= 32'h0000_0000;
    end else begin
      rdata <= {mem[3], mem[2], mem[1], mem[0]};
    end
  end
endmodule

//--- siap_ctl_model.sv
module siap_ctl_model (
  input  wire logic       clk,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  output logic            rx_last
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got[$];
  initial begin
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_last = 1'b0;
  end
  // This originator never opens with configuration data of its own.
  // Ready drops about one cycle in three, so every byte must be held.
  always @(posedge clk) begin
    if (tx_valid && tx_ready) got.push_back(tx_data);
    tx_ready <= ($urandom % 3) != 0;
  end
  task automatic send(input logic [7:0] b[$]);
    for (int i = 0; i < b.size(); i++) begin
      rx_valid <= 1'b1;
      rx_data <= b[i];
      rx_last <= i == b.size() - 1;
      @(posedge clk);
    end
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    rx_data <= ~rx_data;
  endtask
endmodule

//--- siap_packer_asserts.sv
module siap_packer_asserts
  import siap_pkg::*;
(
  input wire logic        CLK_SYS,
  input wire logic        RST,
  input wire siap_in12_t  SAFE_IN_FAULT,
  input wire siap_in12_t  SAFE_IN_USED,
  input wire siap_out4_t  SAFE_OUT_FAULT,
  input wire siap_out4_t  SAFE_OUT_USED,
  input wire siap_power_t POWER_DIAG,
  input wire logic        TX_START,
  input wire logic        TX_READY,
  input wire logic        TX_VALID,
  input wire logic [7:0]  TX_DATA,
  input wire logic        TX_LAST,
  input wire logic        RX_VALID,
  input wire logic        RX_LAST,
  input wire siap_asm_t   RX_ASM,
  input wire siap_out4_t  SAFE_OUT_CMD,
  input wire siap_in12_t  TEST_OUT_CMD,
  input wire logic        RX_DONE,
  input wire logic        RX_ERROR
);
  logic [3:0] tcnt;
  logic [2:0] rcnt;
  logic       len_ok;
  logic       misc;
  logic [3:0] pwr4;
  assign len_ok = rcnt == (RX_ASM == SIAP_ASM_STD ? 3'h0 : 3'h3);
  assign misc = TX_VALID && tcnt == 4'hC;
  assign pwr4 = {POWER_DIAG.unit_oc_ok, POWER_DIAG.out_oc_ok,
                 POWER_DIAG.unit_supply_ok, POWER_DIAG.out_supply_ok};
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      tcnt <= 4'h0;
      rcnt <= 3'h0;
    end else begin
      if (TX_VALID && TX_READY) tcnt <= TX_LAST ? 4'h0 : tcnt + 4'h1;
      if (RX_VALID) rcnt <= RX_LAST ? 3'h0 : rcnt + 3'h1;
    end
  end
  default clocking dc @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);
  start_busy_a: assert property (!TX_VALID && TX_START |=> TX_VALID)
    else $error("start did not raise valid");
  byte_hold_a: assert property (TX_VALID && !TX_READY |=>
    TX_VALID && $stable(TX_DATA) && $stable(TX_LAST)) else $error("byte moved");
  frame_len_a: assert property (TX_VALID |-> TX_LAST == (tcnt == 4'hC))
    else $error("last flag misplaced");
  unused_zero_a: assert property (TX_VALID && !misc && (tcnt[0] || tcnt[3])
    |-> TX_DATA[7:4] == 4'h0 && (!(tcnt == 4'h9 || tcnt == 4'hB) ||
    TX_DATA == 8'h00)) else $error("unused bits set");
  all_in_a: assert property (misc |->
    TX_DATA[3] == &(~SAFE_IN_FAULT | ~SAFE_IN_USED)) else $error("input sum");
  all_out_a: assert property (misc |->
    TX_DATA[2] == &(~SAFE_OUT_FAULT | ~SAFE_OUT_USED))
    else $error("output sum");
  power_bits_a: assert property (misc |->
    {TX_DATA[7:6], TX_DATA[1:0]} == pwr4) else $error("power bits");
  rx_good_a: assert property (RX_VALID && RX_LAST && len_ok |=>
    RX_DONE && !RX_ERROR) else $error("good frame not done");
  rx_bad_a: assert property (RX_VALID && RX_LAST && !len_ok |=>
    RX_ERROR && !RX_DONE && $stable(SAFE_OUT_CMD) && $stable(TEST_OUT_CMD)
    ##1 $stable(SAFE_OUT_CMD) && $stable(TEST_OUT_CMD)) else $error("bad frame");
endmodule
bind siap_packer siap_packer_asserts u_chk (.*);

//--- siap_packer_tb.sv
`include "siap_defines.svh"
module siap_packer_tb
  import siap_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        tx_start = 1'b0;
  logic        tx_valid, tx_last, tx_ready, rx_valid, rx_last;
  logic        rx_done, rx_error;
  logic [7:0]  tx_data, rx_data;
  siap_in12_t  in_n = 12'h000, in_flt = 12'h000, in_used = 12'h000;
  siap_in12_t  tp_out = 12'h000, tp_flt = 12'h000, test_cmd, exp_test;
  siap_out4_t  mon = 4'h0, out_flt = 4'h0, out_used = 4'h0, safe_cmd;
  siap_out4_t  exp_safe = 4'h0;
  siap_power_t pwr = 6'h00;
  logic [23:0] fn = 24'h00_0000;
  siap_asm_t   asm_k = SIAP_ASM_NONE;
  int          bad_count = 0, checks = 0, cyc = 0;
  siap_packer u_dut (
    .CLK_SYS(clk_sys), .RST(rst), .SAFE_IN_N(in_n), .SAFE_IN_FAULT(in_flt),
    .SAFE_IN_USED(in_used), .TEST_PULSE_OUT(tp_out), .TEST_OUT_FAULT(tp_flt),
    .SAFE_OUT_MON(mon), .SAFE_OUT_FAULT(out_flt), .SAFE_OUT_USED(out_used),
    .POWER_DIAG(pwr), .TEST_OUT_FN(fn), .TX_START(tx_start),
    .TX_READY(tx_ready), .TX_VALID(tx_valid), .TX_DATA(tx_data),
    .TX_LAST(tx_last), .RX_VALID(rx_valid), .RX_DATA(rx_data),
    .RX_LAST(rx_last), .RX_ASM(asm_k), .SAFE_OUT_CMD(safe_cmd),
    .TEST_OUT_CMD(test_cmd), .RX_DONE(rx_done), .RX_ERROR(rx_error));
  siap_ctl_model u_ctl (.clk(clk_sys), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_last(rx_last));
  initial forever #50 clk_sys = ~clk_sys;
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      report_and_stop();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic [103:0] exp_frame();
    siap_in12_t hl;
    hl = ~in_flt | ~in_used;
    return {pwr.unit_oc_ok, pwr.out_oc_ok, pwr.lamp7_ok & ~tp_flt[7],
            pwr.lamp3_ok & ~tp_flt[3], &hl, ~|out_flt, pwr.unit_supply_ok,
            pwr.out_supply_ok, 12'h000, ~out_flt, 12'h000, mon, 4'h0, ~tp_flt,
            4'h0, tp_out, 4'h0, hl, 4'h0, in_n & in_used};
  endfunction
  task automatic tx_test();
    logic [103:0] e;
    // Pin inputs need a few edges to cross the synchronisers.
    repeat (6) @(posedge clk_sys);
    e = exp_frame();
    u_ctl.got.delete();
    tx_start <= 1'b1;
    @(posedge clk_sys);
    tx_start <= 1'b0;
    for (int i = 0; i < 100 && u_ctl.got.size() < 13; i++) @(posedge clk_sys);
    check(16'(u_ctl.got.size()), 16'h000D);
    for (int k = 0; k < 13; k++) check({8'h00, u_ctl.got[k]}, {8'h00, e[8*k+:8]});
    $display("tx frame test done");
  endtask
  task automatic rx_test(input int n);
    logic [7:0]  b[$];
    logic [31:0] r;
    r = $urandom;
    for (int i = 0; i < n; i++) b.push_back(r[8*i+:8]);
    u_ctl.send(b);
    if (n == (asm_k == SIAP_ASM_STD ? 1 : 4)) begin
      exp_safe = r[3:0] & out_used;
      for (int i = 0; i < 12; i++) if (asm_k == SIAP_ASM_VND && fn[2*i+:2] == `SIAP_TEST_FN_STD) exp_test[i] = r[16+i];
    end
    #1;
    check({14'h0000, rx_done, rx_error}, {14'h0000, b.size() == n && n == (asm_k == SIAP_ASM_STD ? 1 : 4), n != (asm_k == SIAP_ASM_STD ? 1 : 4)});
    repeat (2) @(posedge clk_sys);
    #1;
    check({safe_cmd, test_cmd}, {exp_safe, exp_test});
    $display("rx frame test done");
  endtask
  initial begin
    logic [31:0] r;
    logic [11:0] f;
    exp_test = 12'h000;
    void'($urandom(19294));
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    for (int t = 0; t < 40; t++) begin
      @(posedge clk_sys);
      r = $urandom;
      f = t < 2 ? {12{t[0]}} : r[11:0] & 12'($urandom & $urandom);
      in_n <= r[11:0];
      in_flt <= f;
      in_used <= t < 2 ? 12'hFFF : r[23:12];
      tp_out <= r[31:20];
      tp_flt <= {f[0], f[11:1]};
      mon <= r[15:12];
      out_flt <= f[7:4];
      out_used <= 4'hF;
      pwr <= t < 2 ? {6{~t[0]}} : ~f[11:6];
      tx_test();
      @(posedge clk_sys);
      r = $urandom;
      out_used <= r[3:0];
      fn <= r[23:0] & r[31:8];
      asm_k <= r[24] ? SIAP_ASM_VND : SIAP_ASM_STD;
      rx_test(r[25] ? (r[24] ? 4 : 1) : 1 + int'(r[27:26]));
    end
    report_and_stop();
  end
endmodule
